/* File: hdl/epi_irq_ctrl.sv */
`timescale 1ns/1ps
// ****************************************************************
// eight source, four level interrupt controller
// ****************************************************************
module epi_irq_ctrl (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // register bus
  input wire epi_pkg::epi_apb_req_type apbReq,
  output epi_pkg::epi_apb_rsp_type apbRsp,
  // request sources
  input wire logic [3:0] extReqPin_n,
  input wire epi_pkg::epi_flag_set_type flagSet,
  // processor core
  input wire logic cpuIrqReturn,
  output epi_pkg::epi_vec_type cpuVec
);
  import epi_pkg::*;

  epi_state_type r_reg;                 // whole state
  epi_state_type r_next;                // next state
  logic [NUM_SRC-1:0] reqVec;           // raw request per source
  logic [NUM_SRC-1:0] enVec;            // per-source enables
  logic [NUM_SRC-1:0] reqEn;            // requests passing enables
  logic [NUM_SRC-1:0][1:0] rank;        // level per source
  logic winValid;
  logic [2:0] winIdx;
  logic [1:0] winRank;
  logic [2:0] curRank;                  // level now in service
  logic grant;                          // vectoring this cycle
  logic wrEn;                           // apb write taking effect
  logic [3:0] fall;                     // falling edge per pin
  logic beatsWin;                       // assertion helper only

  // ****************************************************************
  // request, enable and level gathering
  // ****************************************************************
  // pins 2 and 3 keep their low bits in the ext control register
  always_comb begin
    reqVec[SRC_EXT0] = r_reg.extCtl[EC_FLAG0];
    reqVec[SRC_T0] = r_reg.srcFlag[SF_OVF0];
    reqVec[SRC_EXT1] = r_reg.extCtl[EC_FLAG1];
    reqVec[SRC_T1] = r_reg.srcFlag[SF_OVF1];
    reqVec[SRC_SER] = r_reg.srcFlag[SF_RX] | r_reg.srcFlag[SF_TX];
    reqVec[SRC_T2] = r_reg.srcFlag[SF_OVF2] | r_reg.srcFlag[SF_EXT2];
    reqVec[SRC_EXT2] = r_reg.ext23[X23_FLAG2];
    reqVec[SRC_EXT3] = r_reg.ext23[X23_FLAG3];
    enVec = {r_reg.ext23[X23_EN3], r_reg.ext23[X23_EN2], r_reg.enMask[5:0]};
    for (int i = 0; i < 6; i++) begin
      rank[i] = epiRank(r_reg.prioHi[i], r_reg.prioLo[i]);
    end
    rank[SRC_EXT2] = epiRank(r_reg.prioHi[SRC_EXT2], r_reg.ext23[X23_LOW2]);
    rank[SRC_EXT3] = epiRank(r_reg.prioHi[SRC_EXT3], r_reg.ext23[X23_LOW3]);
    reqEn = reqVec & enVec;
  end

  // ****************************************************************
  // winner search
  // ****************************************************************
  epi_prio_resolve u_resolve (
    .reqEn(reqEn),
    .rank(rank),
    .winValid(winValid),
    .winIdx(winIdx),
    .winRank(winRank)
  );

  // strictly higher level than the one in service may preempt; an
  // equal level waits, so a level-mode pin held low cannot re-enter
  always_comb begin
    curRank = epiFirstSet(r_reg.inSvc);
    grant = winValid && r_reg.enMask[EN_GLOBAL] && ({1'b0, winRank} < curRank);
    wrEn = apbReq.psel && apbReq.penable && r_reg.rsp.pready && apbReq.pwrite;
    fall = r_reg.pinPrev & ~extReqPin_n;
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic [31:0] rd;
    logic hit;
    rd = RD_ZERO;
    hit = 1'b1;
    r_next = r_reg;
    r_next.rsp.pready = 1'b0;
    r_next.rsp.pslverr = 1'b0;
    r_next.vec.ack = 1'b0;

    // read mux, reserved bits already stored as zero
    case (apbReq.paddr)
      OFS_ENABLE: begin
        rd[7:0] = r_reg.enMask;
      end
      OFS_PRIO_LO: begin
        rd[7:0] = r_reg.prioLo;
      end
      OFS_PRIO_HI: begin
        rd[7:0] = r_reg.prioHi;
      end
      OFS_EXT23: begin
        rd[7:0] = r_reg.ext23;
      end
      OFS_EXTCTL: begin
        rd[7:0] = r_reg.extCtl;
      end
      OFS_SRCFLAG: begin
        rd[7:0] = r_reg.srcFlag;
      end
      OFS_STATUS: begin
        rd[NUM_LVL-1:0] = r_reg.inSvc;
        rd[ST_PEND] = winValid;
      end
      default: begin
        hit = 1'b0;
      end
    endcase

    // setup phase: answer is ready in the first access cycle
    if (apbReq.psel && !apbReq.penable) begin
      r_next.rsp.pready = 1'b1;
      r_next.rsp.prdata = rd;
      r_next.rsp.pslverr = ~hit;
    end

    // software writes, flags included
    if (wrEn) begin
      case (apbReq.paddr)
        OFS_ENABLE: begin
          r_next.enMask = apbReq.pwdata[7:0] & ENABLE_WMASK;
        end
        OFS_PRIO_LO: begin
          r_next.prioLo = apbReq.pwdata[7:0] & PRIO_LO_WMASK;
        end
        OFS_PRIO_HI: begin
          r_next.prioHi = apbReq.pwdata[7:0] & PRIO_HI_WMASK;
        end
        OFS_EXT23: begin
          r_next.ext23 = apbReq.pwdata[7:0] & EXT23_WMASK;
        end
        OFS_EXTCTL: begin
          r_next.extCtl = apbReq.pwdata[7:0] & EXTCTL_WMASK;
        end
        OFS_SRCFLAG: begin
          r_next.srcFlag = apbReq.pwdata[7:0] & SRCFLAG_WMASK;
        end
        default: begin
          // status is read only, unmapped writes dropped
        end
      endcase
    end

    // return from service pops the current level
    if (cpuIrqReturn && (curRank != RANK_NONE)) begin
      r_next.inSvc[curRank[1:0]] = 1'b0;
    end

    // vectoring: one-cycle acknowledge, push level, clear some flags
    if (grant) begin
      r_next.vec.ack = 1'b1;
      r_next.vec.vector = epiVector(winIdx);
      r_next.inSvc[winRank] = 1'b1;
      case (winIdx)
        SRC_EXT0: begin
          if (r_reg.extCtl[EC_TYPE0]) begin
            r_next.extCtl[EC_FLAG0] = 1'b0;
          end
        end
        SRC_EXT1: begin
          if (r_reg.extCtl[EC_TYPE1]) begin
            r_next.extCtl[EC_FLAG1] = 1'b0;
          end
        end
        SRC_EXT2: begin
          if (r_reg.ext23[X23_TYPE2]) begin
            r_next.ext23[X23_FLAG2] = 1'b0;
          end
        end
        SRC_EXT3: begin
          if (r_reg.ext23[X23_TYPE3]) begin
            r_next.ext23[X23_FLAG3] = 1'b0;
          end
        end
        SRC_T0: begin
          r_next.srcFlag[SF_OVF0] = 1'b0;
        end
        SRC_T1: begin
          r_next.srcFlag[SF_OVF1] = 1'b0;
        end
        default: begin
          // serial and timer 2 flags stay for software
        end
      endcase
    end

    // hardware sets come last so a set beats any clear
    r_next.srcFlag[SF_OVF0] = r_next.srcFlag[SF_OVF0] | flagSet.t0Ovf;
    r_next.srcFlag[SF_OVF1] = r_next.srcFlag[SF_OVF1] | flagSet.t1Ovf;
    r_next.srcFlag[SF_OVF2] = r_next.srcFlag[SF_OVF2] | flagSet.t2Ovf;
    r_next.srcFlag[SF_EXT2] = r_next.srcFlag[SF_EXT2] | flagSet.t2Ext;
    r_next.srcFlag[SF_RX] = r_next.srcFlag[SF_RX] | flagSet.serRx;
    r_next.srcFlag[SF_TX] = r_next.srcFlag[SF_TX] | flagSet.serTx;

    // external pins: edge mode latches, level mode tracks the pin
    if (r_reg.extCtl[EC_TYPE0]) begin
      r_next.extCtl[EC_FLAG0] = r_next.extCtl[EC_FLAG0] | fall[0];
    end else begin
      r_next.extCtl[EC_FLAG0] = ~extReqPin_n[0];
    end
    if (r_reg.extCtl[EC_TYPE1]) begin
      r_next.extCtl[EC_FLAG1] = r_next.extCtl[EC_FLAG1] | fall[1];
    end else begin
      r_next.extCtl[EC_FLAG1] = ~extReqPin_n[1];
    end
    if (r_reg.ext23[X23_TYPE2]) begin
      r_next.ext23[X23_FLAG2] = r_next.ext23[X23_FLAG2] | fall[2];
    end else begin
      r_next.ext23[X23_FLAG2] = ~extReqPin_n[2];
    end
    if (r_reg.ext23[X23_TYPE3]) begin
      r_next.ext23[X23_FLAG3] = r_next.ext23[X23_FLAG3] | fall[3];
    end else begin
      r_next.ext23[X23_FLAG3] = ~extReqPin_n[3];
    end
    r_next.pinPrev = extReqPin_n;
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      r_reg.enMask <= REG_RESET;
      r_reg.prioLo <= REG_RESET;
      r_reg.prioHi <= REG_RESET;
      r_reg.ext23 <= REG_RESET;
      r_reg.extCtl <= REG_RESET;
      r_reg.srcFlag <= REG_RESET;
      r_reg.pinPrev <= PIN_IDLE;
      r_reg.inSvc <= '0;
      r_reg.rsp <= '0;
      r_reg.vec <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs straight from the state flops
  assign apbRsp = r_reg.rsp;
  assign cpuVec = r_reg.vec;

  // ****************************************************************
  // checks
  // ****************************************************************
  // any enabled request that should have beaten the winner
  always_comb begin
    beatsWin = 1'b0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (reqEn[i] && ((rank[i] < winRank) || ((rank[i] == winRank) && (3'(i) < winIdx)))) begin
        beatsWin = 1'b1;
      end
    end
  end

  sequence s_grant;
    grant;
  endsequence

  sequence s_ack;
    r_reg.vec.ack;
  endsequence

  property p_ackPulse;
    @(posedge core_clk) disable iff (!arst_n) s_ack |=> !r_reg.vec.ack;
  endproperty
  a_ackPulse: assert property (p_ackPulse) else $error("ack longer than one cycle");

  property p_globalOff;
    @(posedge core_clk) disable iff (!arst_n) !r_reg.enMask[EN_GLOBAL] |=> !r_reg.vec.ack;
  endproperty
  a_globalOff: assert property (p_globalOff) else $error("grant with global off");

  property p_enabled;
    @(posedge core_clk) disable iff (!arst_n) s_grant |-> enVec[winIdx] ##1 s_ack;
  endproperty
  a_enabled: assert property (p_enabled) else $error("disabled source granted");

  property p_bestWins;
    @(posedge core_clk) disable iff (!arst_n) s_grant |-> !beatsWin;
  endproperty
  a_bestWins: assert property (p_bestWins) else $error("wrong winner chosen");

  property p_noPreempt;
    @(posedge core_clk) disable iff (!arst_n)
      s_ack |-> ($past(winRank) < $past(curRank[1:0])) || ($past(curRank) == RANK_NONE);
  endproperty
  a_noPreempt: assert property (p_noPreempt) else $error("preempted by lower level");

  property p_vector;
    @(posedge core_clk) disable iff (!arst_n)
      s_ack |-> r_reg.vec.vector == {2'b00, $past(winIdx), 3'b011};
  endproperty
  a_vector: assert property (p_vector) else $error("bad vector address");

  property p_edgeSet;
    @(posedge core_clk) disable iff (!arst_n)
      r_reg.ext23[X23_TYPE2] && fall[2] |=> r_reg.ext23[X23_FLAG2];
  endproperty
  a_edgeSet: assert property (p_edgeSet) else $error("edge on pin 2 missed");

  property p_levelFollow;
    @(posedge core_clk) disable iff (!arst_n)
      !r_reg.extCtl[EC_TYPE0] |=> r_reg.extCtl[EC_FLAG0] == !$past(extReqPin_n[0]);
  endproperty
  a_levelFollow: assert property (p_levelFollow) else $error("level flag not tracking");

  property p_t0Clear;
    @(posedge core_clk) disable iff (!arst_n)
      s_grant and (winIdx == SRC_T0) and !flagSet.t0Ovf |=> !r_reg.srcFlag[SF_OVF0];
  endproperty
  a_t0Clear: assert property (p_t0Clear) else $error("timer 0 flag kept");

  property p_serKeep;
    @(posedge core_clk) disable iff (!arst_n)
      s_grant and (winIdx == SRC_SER) and r_reg.srcFlag[SF_RX] and !wrEn |=> r_reg.srcFlag[SF_RX];
  endproperty
  a_serKeep: assert property (p_serKeep) else $error("serial flag cleared");

  property p_return;
    @(posedge core_clk) disable iff (!arst_n)
      cpuIrqReturn && (curRank != RANK_NONE) && !grant |=> !r_reg.inSvc[$past(curRank[1:0])];
  endproperty
  a_return: assert property (p_return) else $error("return left level active");

endmodule

/* File: hdl/epi_prio_resolve.sv */
`timescale 1ns/1ps
// ****************************************************************
// winner search over enabled requests
// ****************************************************************
module epi_prio_resolve (
  // requests already masked by their enables
  input wire logic [epi_pkg::NUM_SRC-1:0] reqEn,
  input wire logic [epi_pkg::NUM_SRC-1:0][1:0] rank,
  // winner
  output logic winValid,
  output logic [2:0] winIdx,
  output logic [1:0] winRank
);
  import epi_pkg::*;

  // levels outer, polling order inner; first hit wins
  always_comb begin
    winValid = 1'b0;
    winIdx = SRC_EXT0;
    winRank = 2'b00;
    for (int r = 0; r < NUM_LVL; r++) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        if (!winValid && reqEn[i] && (rank[i] == 2'(r))) begin
          winValid = 1'b1;
          winIdx = 3'(i);
          winRank = 2'(r);
        end
      end
    end
  end

endmodule

/* File: shared/epi_pkg.sv */
// ****************************************************************
// ****************************************************************
package epi_pkg;

  // ****************************************************************
  // register map, byte addresses on the apb
  // ****************************************************************
  localparam int APB_ADDR_W = 8;
  localparam logic [7:0] OFS_ENABLE = 8'h00; // irq_enable_mask
  localparam logic [7:0] OFS_PRIO_LO = 8'h04; // irq_priority_low
  localparam logic [7:0] OFS_PRIO_HI = 8'h08; // irq_priority_high
  localparam logic [7:0] OFS_EXT23 = 8'h0C; // ext_irq_control
  localparam logic [7:0] OFS_EXTCTL = 8'h10;   // ext 0/1 type and flags
  localparam logic [7:0] OFS_SRCFLAG = 8'h14;  // timer and serial flags
  localparam logic [7:0] OFS_STATUS = 8'h18;   // in-service and pending
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  // ****************************************************************
  // field positions and write masks
  // ****************************************************************
  localparam int EN_GLOBAL = 7;
  localparam logic [7:0] ENABLE_WMASK = 8'hBF; // bit 6 reserved
  localparam logic [7:0] PRIO_LO_WMASK = 8'h3F; // bits 7:6 reserved
  localparam logic [7:0] PRIO_HI_WMASK = 8'hFF;
  localparam logic [7:0] EXT23_WMASK = 8'hFF;
  localparam int X23_TYPE2 = 0;
  localparam int X23_FLAG2 = 1;
  localparam int X23_EN2 = 2;
  localparam int X23_LOW2 = 3;
  localparam int X23_TYPE3 = 4;
  localparam int X23_FLAG3 = 5;
  localparam int X23_EN3 = 6;
  localparam int X23_LOW3 = 7;
  localparam int EC_TYPE0 = 0;
  localparam int EC_FLAG0 = 1;
  localparam int EC_TYPE1 = 2;
  localparam int EC_FLAG1 = 3;
  localparam logic [7:0] EXTCTL_WMASK = 8'h0F;
  localparam int SF_OVF0 = 0;
  localparam int SF_OVF1 = 1;
  localparam int SF_OVF2 = 2;
  localparam int SF_EXT2 = 3;
  localparam int SF_RX = 4;
  localparam int SF_TX = 5;
  localparam logic [7:0] SRCFLAG_WMASK = 8'h3F;
  localparam int ST_PEND = 4;

  // ****************************************************************
  // sources in polling order, levels, vectors
  // ****************************************************************
  localparam int NUM_SRC = 8;
  localparam int NUM_LVL = 4;
  localparam logic [2:0] SRC_EXT0 = 3'h0;
  localparam logic [2:0] SRC_T0 = 3'h1;
  localparam logic [2:0] SRC_EXT1 = 3'h2;
  localparam logic [2:0] SRC_T1 = 3'h3;
  localparam logic [2:0] SRC_SER = 3'h4;
  localparam logic [2:0] SRC_T2 = 3'h5;
  localparam logic [2:0] SRC_EXT2 = 3'h6;
  localparam logic [2:0] SRC_EXT3 = 3'h7;
  localparam logic [2:0] RANK_NONE = 3'h4;     // nothing in service
  localparam logic [7:0] VEC_BASE = 8'h03;
  localparam logic [3:0] PIN_IDLE = 4'hF;      // request pins idle high

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [APB_ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } epi_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } epi_apb_rsp_type;

  typedef struct packed {
    logic ack;
    logic [7:0] vector;
  } epi_vec_type;

  typedef struct packed {
    logic t0Ovf;
    logic t1Ovf;
    logic t2Ovf;
    logic t2Ext;
    logic serRx;
    logic serTx;
  } epi_flag_set_type;

  typedef struct packed {
    logic [7:0] enMask;
    logic [7:0] prioLo;
    logic [7:0] prioHi;
    logic [7:0] ext23;
    logic [7:0] extCtl;
    logic [7:0] srcFlag;
    logic [3:0] pinPrev;
    logic [NUM_LVL-1:0] inSvc;
    epi_apb_rsp_type rsp;
    epi_vec_type vec;
  } epi_state_type;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // rank 0 is the highest level: pair 1,1 gives 0, pair 0,0 gives 3
  function automatic logic [1:0] epiRank(input logic hi, input logic lo);
    return {~hi, ~lo};
  endfunction

  function automatic logic [7:0] epiVector(input logic [2:0] idx);
    return VEC_BASE + {2'b00, idx, 3'b000};
  endfunction

  // lowest set bit, or RANK_NONE when empty
  function automatic logic [2:0] epiFirstSet(input logic [NUM_LVL-1:0] v);
    logic [2:0] res;
    res = RANK_NONE;
    for (int i = NUM_LVL - 1; i >= 0; i--) begin
      if (v[i]) begin
        res = 3'(i);
      end
    end
    return res;
  endfunction

endpackage

/* File: test/epi_cpu_model.sv */
`timescale 1ns/1ps
// ****************************************************************
// processor core stand-in: takes vectors, returns when told
// ****************************************************************
module epi_cpu_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // vector side
  input wire epi_pkg::epi_vec_type cpuVec,
  output logic cpuIrqReturn,
  // bench control and observation
  input wire logic retReq,
  input wire logic [3:0] retDelay,
  output logic [7:0] ackCount,
  output logic [7:0] lastVec
);
  import epi_pkg::*;
  logic [4:0] waitCnt; // cycles left before the return pulse
  // grant is a one-cycle pulse, so it is taken in the cycle it stands
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ackCount <= 8'h00;
      lastVec <= 8'h00;
      waitCnt <= 5'h00;
      cpuIrqReturn <= 1'b0;
    end else begin
      if (cpuVec.ack) begin
        ackCount <= ackCount + 8'h01;
        lastVec <= cpuVec.vector;
      end
      // slow or prompt return, chosen by the bench per routine
      if (retReq) begin
        waitCnt <= {1'b0, retDelay} + 5'h01;
      end else if (waitCnt != 5'h00) begin
        waitCnt <= waitCnt - 5'h01;
      end
      cpuIrqReturn <= (waitCnt == 5'h01);
    end
  end
endmodule

/* File: test/testbench.sv */
`timescale 1ns/1ps
// ****************************************************************
// self-checking bench for the interrupt controller
// ****************************************************************
module testbench;
  import epi_pkg::*;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  epi_apb_req_type req = '0;
  epi_apb_rsp_type rsp;
  logic [3:0] pins = 4'hF; // request pins idle high
  epi_flag_set_type fset = '0;
  epi_vec_type vec;
  logic irqRet;
  logic retReq = 1'b0;
  logic [3:0] retDelay = 4'h0;
  logic [7:0] ackCount, lastVec;
  logic lastErr;
  logic [15:0] seed = 16'h0035;
  logic [7:0] enR, loR, hiR, xi, ec, sf, e, r, n0, sfE, ecE, xiE, en, rq, lo;
  int errors = 0;
  int checked = 0;
  int cycles = 0;

  epi_irq_ctrl DUT (.core_clk(core_clk), .arst_n(arst_n), .apbReq(req), .apbRsp(rsp),
    .extReqPin_n(pins), .flagSet(fset), .cpuIrqReturn(irqRet), .cpuVec(vec));
  epi_cpu_model cpu (.core_clk(core_clk), .arst_n(arst_n), .cpuVec(vec), .cpuIrqReturn(irqRet),
    .retReq(retReq), .retDelay(retDelay), .ackCount(ackCount), .lastVec(lastVec));

  // ****************************************************************
  // clock, timeout, helpers
  // ****************************************************************
  always #2.5 core_clk = ~core_clk;

  // run limit well above the expected few thousand cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      end_sim();
    end
  end

  function automatic logic [7:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed[7:0];
  endfunction

  // expected vector: best level first, then lowest polling index; FF when none
  function automatic logic [7:0] exp_vec(input logic [7:0] q, hi, lw);
    int best;
    logic [1:0] br, rk;
    best = -1;
    br = 2'h3;
    for (int i = 0; i < 8; i++) begin
      rk = {~hi[i], ~lw[i]};
      if (q[i] && (best < 0 || rk < br)) begin
        best = i;
        br = rk;
      end
    end
    return (best < 0) ? 8'hFF : 8'(8'h03 + 8 * best);
  endfunction

  task automatic ticks(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] rv);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= {24'h000000, d};
    @(posedge core_clk);
    req.penable <= 1'b1;
    @(posedge core_clk);
    // only the bench timeout may end this wait
    while (rsp.pready !== 1'b1) begin
      @(posedge core_clk);
    end
    rv = rsp.prdata[7:0];
    lastErr = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] x;
    apb(1'b1, a, d, x);
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] x);
    checked++;
    if (g !== x) begin
      errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, g, x);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] x);
    logic [7:0] v;
    apb(1'b0, a, 8'h00, v);
    chk(v, x);
  endtask

  // ask the core model for a return, then let it land
  task automatic do_return();
    retReq <= 1'b1;
    @(posedge core_clk);
    retReq <= 1'b0;
    ticks(20);
  endtask

  task automatic pulse(input epi_flag_set_type f);
    fset <= f;
    @(posedge core_clk);
    fset <= '0;
  endtask

  task automatic end_sim();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    ticks(5);
    arst_n <= 1'b1;
    @(posedge core_clk);
    for (int a = 0; a < 8'h1C; a += 4) begin
      rdchk(8'(a), 8'h00);
    end
    apb(1'b0, 8'h1C, 8'h00, r);
    chk({7'h00, lastErr}, 8'h01);
    // level mode: flag follows the pin, kept over vectoring
    pins <= 4'hE;
    wr(OFS_ENABLE, 8'h81);
    ticks(2);
    chk(lastVec, 8'h03);
    rdchk(OFS_EXTCTL, 8'h02);
    pins <= 4'hF;
    ticks(2);
    rdchk(OFS_EXTCTL, 8'h00);
    wr(OFS_ENABLE, 8'h00);
    do_return();
    // edge mode on pin 2: falling edge sets flag, grant clears it
    wr(OFS_EXT23, 8'h05);
    wr(OFS_ENABLE, 8'h80);
    pins <= 4'hB;
    ticks(4);
    chk(lastVec, 8'h33);
    rdchk(OFS_EXT23, 8'h05);
    pins <= 4'hF;
    wr(OFS_ENABLE, 8'h00);
    do_return();
    wr(OFS_EXT23, 8'h00);
    // hardware overflow, equal level waits, higher level preempts
    wr(OFS_ENABLE, 8'h8A);
    pulse('{t0Ovf: 1'b1, default: 1'b0});
    ticks(3);
    chk(lastVec, 8'h0B);
    n0 = ackCount;
    pulse('{t1Ovf: 1'b1, default: 1'b0});
    ticks(4);
    chk(ackCount, n0);
    wr(OFS_PRIO_HI, 8'h08);
    wr(OFS_PRIO_LO, 8'h08);
    ticks(2);
    chk(lastVec, 8'h1B);
    chk(ackCount - n0, 8'h01);
    rdchk(OFS_SRCFLAG, 8'h00);
    wr(OFS_ENABLE, 8'h00);
    // serial and timer 2 sets from hardware, then a software clear
    pulse('{t0Ovf: 1'b0, t1Ovf: 1'b0, default: 1'b1});
    rdchk(OFS_SRCFLAG, 8'h3C);
    wr(OFS_SRCFLAG, 8'h00);
    rdchk(OFS_SRCFLAG, 8'h00);
    do_return();
    do_return();
    rdchk(OFS_STATUS, 8'h00);
    // edge mode first, else the old level mode overwrites written flags
    wr(OFS_EXTCTL, 8'h05);
    wr(OFS_EXT23, 8'h11);
    // random levels, enables and software-set flags
    for (int it = 0; it < 40; it++) begin
      enR = rnd();
      loR = rnd();
      hiR = rnd();
      xi = rnd() | 8'h11;
      ec = (rnd() & 8'h0F) | 8'h05;
      sf = rnd() & 8'h3F;
      r = rnd();
      retDelay <= r[3:0];
      n0 = ackCount;
      wr(OFS_ENABLE, enR & 8'h7F);
      wr(OFS_PRIO_LO, loR);
      wr(OFS_PRIO_HI, hiR);
      wr(OFS_EXTCTL, ec);
      wr(OFS_SRCFLAG, sf);
      wr(OFS_EXT23, xi);
      ticks(3);
      chk(ackCount, n0);
      rdchk(OFS_ENABLE, enR & 8'h3F);
      rdchk(OFS_PRIO_LO, loR & 8'h3F);
      rdchk(OFS_PRIO_HI, hiR);
      en = {xi[6], xi[2], enR[5:0]};
      rq = {xi[5], xi[1], sf[2] | sf[3], sf[4] | sf[5], sf[1], ec[3], sf[0], ec[1]};
      lo = {xi[7], xi[3], loR[5:0]};
      e = exp_vec(rq & en, hiR, lo);
      sfE = sf;
      ecE = ec;
      xiE = xi;
      case (e)
        8'h03: ecE[1] = 1'b0;
        8'h0B: sfE[0] = 1'b0;
        8'h13: ecE[3] = 1'b0;
        8'h1B: sfE[1] = 1'b0;
        8'h33: xiE[1] = 1'b0;
        8'h3B: xiE[5] = 1'b0;
        default: ;
      endcase
      wr(OFS_ENABLE, enR | 8'h80);
      ticks(2);
      rdchk(OFS_SRCFLAG, sfE);
      rdchk(OFS_EXTCTL, ecE);
      rdchk(OFS_EXT23, xiE);
      chk(ackCount - n0, {7'h00, e != 8'hFF});
      if (e != 8'hFF) begin
        chk(lastVec, e);
      end
      wr(OFS_ENABLE, 8'h00);
      do_return();
      // pins 2 and 3 keep their enables, so a leftover flag still pends
      rdchk(OFS_STATUS, {3'h0, (xi[6] & xiE[5]) | (xi[2] & xiE[1]), 4'h0});
    end
    end_sim();
  end
endmodule
